// file: logic/adc_ctrl_pkg.sv
// constants and types for the converter pin control block
package adc_ctrl_pkg;

    // three-state pin levels
    localparam logic [1:0] LVL_LOW = 2'h0;
    localparam logic [1:0] LVL_HIGH = 2'h1;
    localparam logic [1:0] LVL_MID = 2'h2;

    localparam int CLK_MHZ = 50;
    localparam int CAL_LOW_MIN_CYC = 1280;
    localparam int CAL_HIGH_MIN_CYC = 1280;
    localparam int CAL_RUN_CYC = 4000;
    localparam int CNT_W = 32;

    localparam int FS_W = 8;
    localparam logic [7:0] FS_CODE_LOW = 8'h40;
    localparam logic [7:0] FS_CODE_HIGH = 8'hFF;
    localparam logic [7:0] FS_RESET = 8'hFF;
    localparam int SER_W = 16;

    typedef enum logic [3:0] {
        ST_PWRUP_WAIT = 4'h1,
        ST_IDLE = 4'h2,
        ST_CAL_RUN = 4'h4,
        ST_POWERED_DOWN = 4'h8
    } cal_state_type;

    typedef struct packed {
        logic ext_mode;
        logic diff_style;
        logic alt_enable;
        logic range_high;
        logic cs_mode;
        logic long_delay;
    } mode_type;

    localparam mode_type MODE_RESET = 6'h04;

endpackage

// file: logic/adc_pin_mode_and_cal_control.sv
// pin mode decode, calibration sequencing and output clock resync
`timescale 1ns/1ns
// What this block does
// R01: power-down pin high stops calibration, sampling and the output data clock; pin decode and serial shift keep running.
// R02: calibration starts after request held low then high for minimum cycle counts.
// R03: single-ended style: positive resync pulse resets the output data clock.
// R04: differential style: resync pin is the positive half of the resync pulse.
// R05: range pin has range/alternate roles only while style pin high/floating; alternate enable also needs enable pin high/floating.
// R06: range select low chooses the reduced full-scale range.
// R07: range select high chooses the higher full-scale range.
// R08: range pin floating enables extended control mode.
// R09: dedicated extended enable pin overrides the alternate enable.
// R10: style select low makes range pin the negative resync half.
// R11: differential style forces the higher full-scale range.
// R12: in pin mode, delay pin level picks power-up calibration delay.
// R13: range pin floating and enable low makes delay pin the chip select.
// R14: while delay pin is chip select, delay setting is forced to zero.
// R15: analogue input is sampled on falling edge of the positive clock leg.
// R16: extended mode takes full scale from the adjust register.
// R17: enable pin low activates extended mode, high leaves pin control.
// R18: style pin high or floating gives single-ended resync.
// R19: calibration flag stays high while calibration runs.
// R20: extended mode turns amplitude pin into serial clock for serial data.
// R21: calibration request is synchronised and low/high runs are counted.
// R22: a floating pin is a third level distinct from high and low.
module adc_pin_mode_and_cal_control #(
    parameter int DELAY_SHORT_CYC = 1024,
    parameter int DELAY_LONG_CYC = 65536
) (
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic clk_en_in,
    input wire logic full_power_down_pin_in,
    input wire logic cal_request_in,
    input wire logic resync_pulse_pos_in,
    input wire logic [1:0] range_pin_in,
    input wire logic [1:0] resync_style_select_in,
    input wire logic [1:0] ext_ctrl_enable_pin_in,
    input wire logic cal_delay_pin_in,
    input wire logic [7:0] fs_adjust_reg_in,
    input wire logic amplitude_sclk_in,
    input wire logic serial_input_line_in,
    output logic power_down_out,
    output logic sample_enable_out,
    output logic cal_in_progress_out,
    output logic output_clock_resync_out,
    output logic output_data_clock_out,
    output logic ext_ctrl_mode_out,
    output logic alternate_ext_ctrl_enable_out,
    output logic resync_differential_out,
    output logic range_high_out,
    output logic [7:0] full_scale_out,
    output logic serial_chip_select_out,
    output logic cal_start_delay_out,
    output logic [15:0] serial_word_out
);

    // ---------------------------------------------
    // pin level decode
    // ---------------------------------------------
    function automatic logic high_or_float(input logic [1:0] lvl);
        return (lvl == adc_ctrl_pkg::LVL_HIGH) || (lvl == adc_ctrl_pkg::LVL_MID); // R22
    endfunction

    localparam logic [31:0] CAL_LOW_MIN = 32'(adc_ctrl_pkg::CAL_LOW_MIN_CYC);
    localparam logic [31:0] CAL_HIGH_MIN = 32'(adc_ctrl_pkg::CAL_HIGH_MIN_CYC);
    localparam logic [31:0] CAL_RUN_LAST = 32'(adc_ctrl_pkg::CAL_RUN_CYC - 1);
    localparam logic [31:0] DLY_SHORT = 32'(DELAY_SHORT_CYC);
    localparam logic [31:0] DLY_LONG = 32'(DELAY_LONG_CYC);

    adc_ctrl_pkg::mode_type mode_next;
    adc_ctrl_pkg::mode_type mode_reg;
    logic style_single;

    always_comb begin
        style_single = high_or_float(resync_style_select_in); // R18
        mode_next.diff_style = !style_single; // R10
        // alternate enable only with style and enable pins high or floating
        mode_next.alt_enable = style_single && high_or_float(ext_ctrl_enable_pin_in)
            && (range_pin_in == adc_ctrl_pkg::LVL_MID); // R05 R08
        if (ext_ctrl_enable_pin_in == adc_ctrl_pkg::LVL_LOW) begin
            mode_next.ext_mode = 1'b1; // R17 R09
        end else if (ext_ctrl_enable_pin_in == adc_ctrl_pkg::LVL_HIGH) begin
            mode_next.ext_mode = 1'b0; // R17 R09
        end else begin
            mode_next.ext_mode = mode_next.alt_enable; // R08
        end
        if (!style_single) begin
            mode_next.range_high = 1'b1; // R11
        end else begin
            mode_next.range_high = (range_pin_in != adc_ctrl_pkg::LVL_LOW); // R06 R07
        end
        mode_next.cs_mode = style_single && (range_pin_in == adc_ctrl_pkg::LVL_MID)
            && mode_next.ext_mode; // R13
        mode_next.long_delay = mode_next.cs_mode ? 1'b0 : cal_delay_pin_in; // R12 R14
    end

    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            mode_reg <= adc_ctrl_pkg::MODE_RESET;
        end else if (clk_en_in) begin
            mode_reg <= mode_next;
        end
    end

    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            full_scale_out <= adc_ctrl_pkg::FS_RESET;
        end else if (clk_en_in) begin
            if (mode_next.ext_mode) begin
                full_scale_out <= fs_adjust_reg_in; // R16
            end else begin
                full_scale_out <= mode_next.range_high ? adc_ctrl_pkg::FS_CODE_HIGH
                    : adc_ctrl_pkg::FS_CODE_LOW; // R06 R07 R11
            end
        end
    end

    assign ext_ctrl_mode_out = mode_reg.ext_mode;
    assign alternate_ext_ctrl_enable_out = mode_reg.alt_enable;
    assign resync_differential_out = mode_reg.diff_style;
    assign range_high_out = mode_reg.range_high;
    assign serial_chip_select_out = mode_reg.cs_mode;
    assign cal_start_delay_out = mode_reg.long_delay;

    // ---------------------------------------------
    // calibration request qualification
    // ---------------------------------------------
    logic cal_meta_reg;
    logic cal_sync_reg;
    logic [31:0] low_cnt_reg;
    logic [31:0] high_cnt_reg;
    logic low_seen_reg;
    logic cal_qualified;

    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            cal_meta_reg <= 1'b0;
            cal_sync_reg <= 1'b0;
        end else if (clk_en_in) begin
            cal_meta_reg <= cal_request_in; // R21
            cal_sync_reg <= cal_meta_reg;
        end
    end

    // low run arms, high run then qualifies
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            low_cnt_reg <= 32'h0;
            high_cnt_reg <= 32'h0;
            low_seen_reg <= 1'b0;
        end else if (clk_en_in) begin
            if (!cal_sync_reg) begin
                high_cnt_reg <= 32'h0;
                if (low_cnt_reg < CAL_LOW_MIN) begin
                    low_cnt_reg <= low_cnt_reg + 32'h1; // R21
                end
                if (low_cnt_reg + 32'h1 >= CAL_LOW_MIN) begin
                    low_seen_reg <= 1'b1; // R02
                end
            end else begin
                low_cnt_reg <= 32'h0;
                if (cal_qualified) begin
                    low_seen_reg <= 1'b0;
                end
                if (low_seen_reg && high_cnt_reg < CAL_HIGH_MIN) begin
                    high_cnt_reg <= high_cnt_reg + 32'h1; // R21
                end
            end
        end
    end

    assign cal_qualified = cal_sync_reg && low_seen_reg && (high_cnt_reg + 32'h1 >= CAL_HIGH_MIN); // R02

    // ---------------------------------------------
    // calibration state machine
    // ---------------------------------------------
    adc_ctrl_pkg::cal_state_type state_reg;
    adc_ctrl_pkg::cal_state_type state_next;
    logic [31:0] cnt_reg;
    logic [31:0] delay_limit;

    assign delay_limit = mode_next.long_delay ? DLY_LONG : DLY_SHORT; // R12 R14

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            adc_ctrl_pkg::ST_PWRUP_WAIT: begin
                if (cnt_reg + 32'h1 >= delay_limit) begin
                    state_next = adc_ctrl_pkg::ST_CAL_RUN; // R12
                end
            end
            adc_ctrl_pkg::ST_IDLE: begin
                if (cal_qualified) begin
                    state_next = adc_ctrl_pkg::ST_CAL_RUN; // R02
                end
            end
            adc_ctrl_pkg::ST_CAL_RUN: begin
                if (cnt_reg == CAL_RUN_LAST) begin
                    state_next = adc_ctrl_pkg::ST_IDLE;
                end
            end
            adc_ctrl_pkg::ST_POWERED_DOWN: begin
                state_next = adc_ctrl_pkg::ST_IDLE;
            end
            default: begin
                state_next = adc_ctrl_pkg::ST_PWRUP_WAIT;
            end
        endcase
        if (full_power_down_pin_in) begin
            state_next = adc_ctrl_pkg::ST_POWERED_DOWN; // R01
        end
    end

    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            state_reg <= adc_ctrl_pkg::ST_PWRUP_WAIT;
            cnt_reg <= 32'h0;
        end else if (clk_en_in) begin
            state_reg <= state_next;
            if (state_next != state_reg) begin
                cnt_reg <= 32'h0;
            end else begin
                cnt_reg <= cnt_reg + 32'h1;
            end
        end
    end

    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            cal_in_progress_out <= 1'b0;
            power_down_out <= 1'b0;
        end else if (clk_en_in) begin
            cal_in_progress_out <= (state_next == adc_ctrl_pkg::ST_CAL_RUN); // R19
            power_down_out <= (state_next == adc_ctrl_pkg::ST_POWERED_DOWN); // R01
        end
    end

    // clk_in stands for the inverted positive clock leg, so its rise is the sampling edge
    assign sample_enable_out = clk_en_in && !power_down_out; // R15 R01

    // ---------------------------------------------
    // output clock resync
    // ---------------------------------------------
    logic pos_prev_reg;
    logic resync_level;

    always_comb begin
        if (mode_next.diff_style) begin
            resync_level = resync_pulse_pos_in && (range_pin_in == adc_ctrl_pkg::LVL_LOW); // R04 R10
        end else begin
            resync_level = resync_pulse_pos_in; // R03
        end
    end

    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            pos_prev_reg <= 1'b0;
            output_clock_resync_out <= 1'b0;
        end else if (clk_en_in) begin
            pos_prev_reg <= resync_level;
            output_clock_resync_out <= resync_level && !pos_prev_reg; // R03 R04
        end
    end

    // output data clock divider, restarted by the resync pulse
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            output_data_clock_out <= 1'b0;
        end else if (clk_en_in) begin
            if (resync_level && !pos_prev_reg || power_down_out) begin
                output_data_clock_out <= 1'b0; // R03 R04 R01
            end else begin
                output_data_clock_out <= !output_data_clock_out;
            end
        end
    end

    // ---------------------------------------------
    // serial shift input in extended mode
    // ---------------------------------------------
    logic sclk_prev_reg;

    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            sclk_prev_reg <= 1'b0;
            serial_word_out <= 16'h0000;
        end else if (clk_en_in) begin
            sclk_prev_reg <= amplitude_sclk_in;
            if (mode_reg.ext_mode && amplitude_sclk_in && !sclk_prev_reg) begin
                serial_word_out <= {serial_word_out[14:0], serial_input_line_in}; // R20
            end
        end
    end

    // ---------------------------------------------
    // checks
    // ---------------------------------------------
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);

    sequence s_pd_req;
        clk_en_in && full_power_down_pin_in;
    endsequence

    sequence s_qualify;
        clk_en_in && cal_qualified && state_reg == adc_ctrl_pkg::ST_IDLE && !full_power_down_pin_in;
    endsequence

    a_power_down_entry: assert property (s_pd_req |=> power_down_out && !cal_in_progress_out) // R01
        else $error("power down not entered");
    a_cal_start: assert property (s_qualify |=> cal_in_progress_out) // R02
        else $error("qualified request did not start calibration");
    a_cal_needs_high: assert property ($rose(cal_in_progress_out) && $past(state_reg) == adc_ctrl_pkg::ST_IDLE
        |-> $past(high_cnt_reg) + 32'h1 >= CAL_HIGH_MIN) // R02
        else $error("calibration began without high run");
    a_se_resync: assert property (clk_en_in && style_single && resync_pulse_pos_in && !pos_prev_reg
        |=> output_clock_resync_out && !output_data_clock_out) // R03
        else $error("single-ended resync missed");
    a_diff_resync: assert property (clk_en_in && !style_single && resync_pulse_pos_in
        && range_pin_in != adc_ctrl_pkg::LVL_LOW |=> !output_clock_resync_out) // R04
        else $error("differential resync without negative half");
    a_range_low: assert property (clk_en_in && style_single && range_pin_in == adc_ctrl_pkg::LVL_LOW
        |=> !range_high_out) // R06
        else $error("low range not chosen");
    a_range_high: assert property (clk_en_in && range_pin_in == adc_ctrl_pkg::LVL_HIGH |=> range_high_out) // R07
        else $error("high range not chosen");
    a_diff_range: assert property (clk_en_in && !style_single |=> range_high_out && resync_differential_out) // R11
        else $error("differential style lost default range");
    a_ece_priority: assert property (clk_en_in && ext_ctrl_enable_pin_in == adc_ctrl_pkg::LVL_HIGH
        |=> !ext_ctrl_mode_out) // R09
        else $error("dedicated enable did not override");
    a_alt_enable: assert property (clk_en_in && style_single && ext_ctrl_enable_pin_in == adc_ctrl_pkg::LVL_MID
        && range_pin_in == adc_ctrl_pkg::LVL_MID |=> ext_ctrl_mode_out) // R08
        else $error("alternate enable ignored");
    a_cs_zero: assert property (serial_chip_select_out |-> !cal_start_delay_out) // R14
        else $error("delay not forced with chip select");
    a_fs_reg: assert property (clk_en_in && ext_ctrl_enable_pin_in == adc_ctrl_pkg::LVL_LOW
        |=> full_scale_out == $past(fs_adjust_reg_in)) // R16
        else $error("full scale not from adjust register");
    a_cal_flag: assert property (cal_in_progress_out |-> state_reg == adc_ctrl_pkg::ST_CAL_RUN) // R19
        else $error("calibration flag without calibration");

endmodule

// file: dv/host_pin_model.sv
// host model driving the calibration request pin
`timescale 1ns/1ns
module host_pin_model (
    input wire logic clk_in,
    input wire logic start_in,
    input wire logic [15:0] low_cyc_in,
    input wire logic [15:0] high_cyc_in,
    output logic cal_request_out,
    output logic busy_out
);
    initial begin
        cal_request_out = 1'b1;
        busy_out = 1'b0;
        forever begin
            @(posedge clk_in);
            if (start_in) begin
                @(negedge clk_in);
                busy_out = 1'b1;
                cal_request_out = 1'b0;
                repeat (low_cyc_in) @(negedge clk_in);
                cal_request_out = 1'b1;
                repeat (high_cyc_in) @(negedge clk_in);
                busy_out = 1'b0;
            end
        end
    end
endmodule

// file: dv/tb_adc_pin_mode_and_cal_control.sv
// self-checking bench for pin decode, calibration and resync
`timescale 1ns/1ns
module tb_adc_pin_mode_and_cal_control;
    localparam int DS = 16;
    localparam int DL = 64;
    logic clk_in, sys_rst_in, clk_en_in, full_power_down_pin_in, cal_request_in, resync_pulse_pos_in;
    logic cal_delay_pin_in, amplitude_sclk_in, serial_input_line_in, start, busy, d, e, cs;
    logic [1:0] range_pin_in, resync_style_select_in, ext_ctrl_enable_pin_in;
    logic [7:0] fs_adjust_reg_in, full_scale_out;
    logic power_down_out, sample_enable_out, cal_in_progress_out, output_clock_resync_out, output_data_clock_out;
    logic ext_ctrl_mode_out, resync_differential_out, range_high_out, serial_chip_select_out, cal_start_delay_out;
    logic alternate_ext_ctrl_enable_out;
    logic [15:0] serial_word_out, lo_cyc, hi_cyc;
    int n_errors, cmp_count, n, k;
    logic [31:0] rnd;
    adc_pin_mode_and_cal_control #(.DELAY_SHORT_CYC(DS), .DELAY_LONG_CYC(DL)) adc_pin_mode_and_cal_control_inst (
        .clk_in(clk_in), .sys_rst_in(sys_rst_in), .clk_en_in(clk_en_in),
        .full_power_down_pin_in(full_power_down_pin_in), .cal_request_in(cal_request_in),
        .resync_pulse_pos_in(resync_pulse_pos_in), .range_pin_in(range_pin_in),
        .resync_style_select_in(resync_style_select_in), .ext_ctrl_enable_pin_in(ext_ctrl_enable_pin_in),
        .cal_delay_pin_in(cal_delay_pin_in), .fs_adjust_reg_in(fs_adjust_reg_in),
        .amplitude_sclk_in(amplitude_sclk_in), .serial_input_line_in(serial_input_line_in),
        .power_down_out(power_down_out), .sample_enable_out(sample_enable_out),
        .cal_in_progress_out(cal_in_progress_out), .output_clock_resync_out(output_clock_resync_out),
        .output_data_clock_out(output_data_clock_out), .ext_ctrl_mode_out(ext_ctrl_mode_out),
        .alternate_ext_ctrl_enable_out(alternate_ext_ctrl_enable_out),
        .resync_differential_out(resync_differential_out),
        .range_high_out(range_high_out), .full_scale_out(full_scale_out),
        .serial_chip_select_out(serial_chip_select_out), .cal_start_delay_out(cal_start_delay_out),
        .serial_word_out(serial_word_out));
    host_pin_model host_pin_model_inst (.clk_in(clk_in), .start_in(start), .low_cyc_in(lo_cyc),
        .high_cyc_in(hi_cyc), .cal_request_out(cal_request_in), .busy_out(busy));
    initial begin
        clk_in = 1'b0;
        forever #10 clk_in = ~clk_in;
    end
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic report_and_stop();
        $display("errors %0d comparisons %0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wait_cal(input int maxc, output int c);
        c = 0;
        while (cal_in_progress_out !== 1'b1) begin
            if (c >= maxc) begin
                n_errors++;
                $display("[FAIL] cal_in_progress expected 1 seen %b", cal_in_progress_out);
                report_and_stop();
            end
            @(negedge clk_in);
            c++;
        end
    endtask
    task automatic measure_run();
        k = 0;
        while (cal_in_progress_out === 1'b1 && k < 5000) begin
            @(negedge clk_in);
            k++;
        end
        chk("cal_run_len", 16'(adc_ctrl_pkg::CAL_RUN_CYC), 16'(k));
    endtask
    task automatic set_pins(input logic [1:0] st, input logic [1:0] rg, input logic [1:0] ec);
        resync_style_select_in = st;
        range_pin_in = rg;
        ext_ctrl_enable_pin_in = ec;
        repeat (3) @(negedge clk_in);
    endtask
    initial begin
        n_errors = 0;
        cmp_count = 0;
        rnd = 32'h00017BA9;
        {sys_rst_in, clk_en_in, cal_delay_pin_in} = 3'h7;
        {full_power_down_pin_in, resync_pulse_pos_in, amplitude_sclk_in, serial_input_line_in, start} = 5'h00;
        {lo_cyc, hi_cyc, fs_adjust_reg_in} = 40'h0000000000;
        {resync_style_select_in, range_pin_in, ext_ctrl_enable_pin_in} = 6'h15;
        for (int i = 0; i < 2; i++) begin
            cal_delay_pin_in = (i == 0);
            sys_rst_in = 1'b1;
            repeat (12) @(negedge clk_in);
            sys_rst_in = 1'b0;
            wait_cal(DL + 40, n);
            if (i == 0) chk("long_delay", 16'(DL), 16'(n));
            else chk("short_delay", 16'(DS), 16'(n));
            measure_run();
        end
        // ---------------------------------------------------------
        // random pin decode
        // ---------------------------------------------------------
        for (int i = 0; i < 40; i++) begin
            rnd = lfsr(rnd);
            fs_adjust_reg_in = rnd[19:12];
            cal_delay_pin_in = rnd[20];
            set_pins(2'(rnd[7:4] % 3), 2'(rnd[3:0] % 3), 2'(rnd[11:8] % 3));
            d = (resync_style_select_in == adc_ctrl_pkg::LVL_LOW);
            cs = !d && range_pin_in == adc_ctrl_pkg::LVL_MID;
            e = ext_ctrl_enable_pin_in == adc_ctrl_pkg::LVL_LOW || (ext_ctrl_enable_pin_in == adc_ctrl_pkg::LVL_MID && cs);
            cs = cs && e;
            chk("diff", 16'(d), 16'(resync_differential_out));
            chk("ext", 16'(e), 16'(ext_ctrl_mode_out));
            chk("cs", 16'(cs), 16'(serial_chip_select_out));
            chk("alt", 16'(!d && ext_ctrl_enable_pin_in != adc_ctrl_pkg::LVL_LOW
                && range_pin_in == adc_ctrl_pkg::LVL_MID), 16'(alternate_ext_ctrl_enable_out));
            chk("range", 16'(d || range_pin_in != adc_ctrl_pkg::LVL_LOW), 16'(range_high_out));
            chk("delay", 16'(cal_delay_pin_in && !cs), 16'(cal_start_delay_out));
            if (e) chk("fs_ext", 16'(fs_adjust_reg_in), 16'(full_scale_out));
            else if (d) chk("fs_diff", 16'(adc_ctrl_pkg::FS_CODE_HIGH), 16'(full_scale_out));
            else if (range_pin_in != adc_ctrl_pkg::LVL_MID)
                chk("fs_pin", range_pin_in[0] ? 16'(adc_ctrl_pkg::FS_CODE_HIGH)
                    : 16'(adc_ctrl_pkg::FS_CODE_LOW), 16'(full_scale_out));
        end
        set_pins(2'h1, 2'h1, 2'h1);
        // ---------------------------------------------------------
        // calibration request, short then valid, then power down
        // ---------------------------------------------------------
        for (int i = 0; i < 2; i++) begin
            lo_cyc = (i == 0) ? 16'h03E8 : 16'h0500;
            hi_cyc = (i == 0) ? 16'h0578 : 16'h0500;
            start = 1'b1;
            @(negedge clk_in);
            start = 1'b0;
            if (i == 0) begin
                repeat (2600) begin
                    @(negedge clk_in);
                    if (cal_in_progress_out !== 1'b0) chk("short_req", 16'h0000, 16'(cal_in_progress_out));
                end
            end else begin
                wait_cal(2620, n);
                chk("req_early", 16'h0001, 16'(n >= 2555));
                measure_run();
            end
        end
        start = 1'b1;
        @(negedge clk_in);
        start = 1'b0;
        wait_cal(2620, n);
        full_power_down_pin_in = 1'b1;
        repeat (2) @(negedge clk_in);
        chk("pd", 16'h0001, 16'(power_down_out));
        chk("pd_cal", 16'h0000, 16'(cal_in_progress_out));
        chk("pd_sample", 16'h0000, 16'(sample_enable_out));
        full_power_down_pin_in = 1'b0;
        repeat (3) @(negedge clk_in);
        chk("pd_exit", 16'h0000, 16'({power_down_out, cal_in_progress_out}));
        k = output_data_clock_out;
        @(negedge clk_in);
        chk("output_data_clock_toggle", 16'(!k), 16'(output_data_clock_out));
        clk_en_in = 1'b0;
        k = output_data_clock_out;
        repeat (3) @(negedge clk_in);
        chk("output_data_clock_freeze", 16'(k), 16'({sample_enable_out, output_data_clock_out}));
        clk_en_in = 1'b1;
        // ---------------------------------------------------------
        // resync in both styles
        // ---------------------------------------------------------
        for (int i = 0; i < 4; i++) begin
            set_pins(i < 2 ? 2'(i + 1) : 2'h0, (i == 3) ? 2'h1 : 2'h0, 2'h1);
            resync_pulse_pos_in = 1'b1;
            n = 0;
            repeat (4) begin
                @(negedge clk_in);
                if (output_clock_resync_out === 1'b1) begin
                    n++;
                    chk("output_data_clock_reset", 16'h0000, 16'(output_data_clock_out));
                end
            end
            chk("resync_count", (i == 3) ? 16'h0000 : 16'h0001, 16'(n));
            resync_pulse_pos_in = 1'b0;
        end
        // ---------------------------------------------------------
        // serial word in extended mode
        // ---------------------------------------------------------
        set_pins(2'h1, 2'h1, 2'h0);
        rnd = lfsr(rnd);
        for (int i = 15; i >= 0; i--) begin
            serial_input_line_in = rnd[i];
            amplitude_sclk_in = 1'b0;
            repeat (2) @(negedge clk_in);
            amplitude_sclk_in = 1'b1;
            repeat (2) @(negedge clk_in);
        end
        chk("serial_word", rnd[15:0], serial_word_out);
        report_and_stop();
    end
    initial begin
        repeat (90000) @(posedge clk_in);
        n_errors++;
        $display("[FAIL] run_length expected end seen timeout");
        report_and_stop();
    end
endmodule
